// >>> src/tlw_pkg.sv
/*
 * Shared constants and types for the tap latency and second-tap window timer.
 * Assumes a 100 MHz system clock and an 8-bit register port from the serial front end.
 */
package tlw_pkg;

    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam int CLK_PERIOD_NS = 10;
    // Finest step of the tap timing, the pulse width step at the fastest rate with the filter off.
    localparam int BASE_STEP_NS = 625000;
    localparam int BASE_STEP_CYCLES = BASE_STEP_NS / CLK_PERIOD_NS;
    // Wide enough for the base step shifted by the largest step shift of eight.
    localparam int PRESCALE_W = 24;
    localparam int SHIFT_W = 4;
    localparam int COUNT_W = 8;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] SECOND_TAP_WINDOW_ADDR = 8'h28;
    localparam logic [7:0] SECOND_TAP_WINDOW_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ========================================================================
    // Rate and mode encodings
    // ========================================================================
    localparam logic [2:0] ODR_800 = 3'h0;
    localparam logic [2:0] ODR_400 = 3'h1;
    localparam logic [2:0] ODR_200 = 3'h2;
    localparam logic [2:0] ODR_100 = 3'h3;
    localparam logic [2:0] ODR_50 = 3'h4;
    localparam logic [2:0] ODR_12_5 = 3'h5;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_LOW_NOISE_LOW_POWER = 2'h1,
        MODE_HIGH_RESOLUTION = 2'h2,
        MODE_LOW_POWER = 2'h3
    } tlw_mode_t;

    // Gray-coded along idle, latency, window, width.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LATENCY = 2'h1,
        ST_WINDOW = 2'h3,
        ST_WIDTH = 2'h2
    } tlw_state_t;

    // ========================================================================
    // Step selection
    // ========================================================================
    // Width step as a power-of-two multiple of the base step; the latency and
    // window steps are always twice this. Enabling the filter is not a plain
    // doubling: in several modes it lengthens the step fourfold, so each filter
    // setting has a table of its own.
    function automatic logic [SHIFT_W-1:0] half_step_shift(input logic [2:0] output_sample_rate, input tlw_mode_t mode,
                                                           input logic filter_en);
        logic [SHIFT_W-1:0] r;
        logic [SHIFT_W-1:0] s;
        r = SHIFT_W'(output_sample_rate);
        s = 4'h0;
        if (filter_en) begin
            unique case (mode)
                MODE_HIGH_RESOLUTION: s = (output_sample_rate == ODR_800) ? 4'h1 : 4'h2;
                MODE_NORMAL: s = (output_sample_rate <= ODR_50) ? r + 4'h1 : 4'h5;
                MODE_LOW_NOISE_LOW_POWER: s = (output_sample_rate <= ODR_50) ? r + 4'h1 : 4'h7;
                MODE_LOW_POWER: begin
                    if (output_sample_rate <= ODR_50) s = r + 4'h1;
                    else if (output_sample_rate == ODR_12_5) s = 4'h7;
                    else s = 4'h8;
                end
            endcase
        end else begin
            unique case (mode)
                MODE_HIGH_RESOLUTION: s = 4'h0;
                MODE_NORMAL: begin
                    if (output_sample_rate <= ODR_400) s = 4'h0;
                    else if (output_sample_rate <= ODR_50) s = r - 4'h1;
                    else s = 4'h3;
                end
                MODE_LOW_NOISE_LOW_POWER: begin
                    if (output_sample_rate <= ODR_400) s = 4'h0;
                    else if (output_sample_rate <= ODR_50) s = r - 4'h1;
                    else s = 4'h5;
                end
                MODE_LOW_POWER: s = (output_sample_rate <= ODR_50) ? r : 4'h6;
            endcase
        end
        return s;
    endfunction

endpackage

// >>> src/tlw_step_tick.sv
/*
 * Programmable prescaler: one-cycle tick every (BASE_CYCLES << shift) clocks.
 * Assumes shift is stable while a timing sequence runs; restart realigns phase.
 */
`timescale 1ns/1ns
`default_nettype none

module tlw_step_tick #(
    parameter int CNT_W = 24,
    parameter int BASE_CYCLES = 62500
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_restart,
    input wire logic [tlw_pkg::SHIFT_W-1:0] i_shift,
    output logic o_tick
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } tlw_tick_st_t;

    tlw_tick_st_t st_r;
    tlw_tick_st_t st_nxt;
    logic [CNT_W-1:0] reload;

    always_comb begin
        reload = (CNT_W'(BASE_CYCLES) << i_shift) - CNT_W'(1);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (i_restart) begin
            st_nxt.cnt = reload;
        end else if (st_r.cnt == '0) begin
            st_nxt.cnt = reload;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_tick = st_r.tick;

endmodule

`default_nettype wire

// >>> src/tlw_tap_timer.sv
/*
 * Tap latency and second-tap window timer with its window register.
 * Assumes the pulse detector delivers one-cycle start/end strobes, synchronous to i_clk,
 * and that rate, mode and filter settings only change while the timer is idle.
 */
`timescale 1ns/1ns
`default_nettype none

module tlw_tap_timer #(
    parameter int BASE_STEP_CYCLES = tlw_pkg::BASE_STEP_CYCLES,
    parameter int PRESCALE_W = tlw_pkg::PRESCALE_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr_en,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd_en,
    output logic [7:0] o_reg_rdata,
    input wire logic [2:0] i_output_sample_rate,
    input wire logic [1:0] i_power_mode,
    input wire logic i_tap_filter_enable,
    input wire logic i_double_tap_enable,
    input wire logic [7:0] i_latency_limit,
    input wire logic [7:0] i_tap_time_limit,
    input wire logic i_first_pulse_detected,
    input wire logic i_pulse_start,
    input wire logic i_pulse_end,
    output logic o_latency_active,
    output logic o_window_open,
    output logic o_second_tap_detected,
    output logic o_second_tap_rejected
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        tlw_pkg::tlw_state_t state;
        logic [7:0] latency_cnt;
        logic [7:0] window_cnt;
        logic [7:0] width_cnt;
        logic phase;
        logic [7:0] window_count_field;
        logic [7:0] rdata;
        logic latency_active;
        logic window_open;
        logic detected;
        logic rejected;
    } tlw_main_st_t;

    tlw_main_st_t st_r;
    tlw_main_st_t st_nxt;
    logic [tlw_pkg::SHIFT_W-1:0] shift;
    logic half_tick;
    logic step_tick;
    logic restart;

    // ========================================================================
    // Step timing
    // ========================================================================
    assign shift = tlw_pkg::half_step_shift(i_output_sample_rate, tlw_pkg::tlw_mode_t'(i_power_mode),
                                            i_tap_filter_enable);
    // The sequence starts with the first pulse, so the prescaler is realigned there
    // and the first latency step is a full step rather than a partial one.
    assign restart = (st_r.state == tlw_pkg::ST_IDLE) && i_first_pulse_detected;
    // Latency and window steps are two width steps.
    // The width count is not realigned at the second start, so its first step may be
    // short by up to one width step; the limit is therefore met to within one step.
    assign step_tick = half_tick && st_r.phase;

    tlw_step_tick #(
        .CNT_W(PRESCALE_W),
        .BASE_CYCLES(BASE_STEP_CYCLES)
    ) u_step_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_restart(restart),
        .i_shift(shift),
        .o_tick(half_tick)
    );

    // ========================================================================
    // Sequencer and register port
    // ========================================================================
    always_comb begin
        st_nxt = st_r;
        st_nxt.detected = 1'b0;
        st_nxt.rejected = 1'b0;
        if (half_tick) begin
            st_nxt.phase = ~st_r.phase;
        end

        unique case (st_r.state)
            tlw_pkg::ST_IDLE: begin
                if (i_first_pulse_detected) begin
                    st_nxt.phase = 1'b0;
                    st_nxt.latency_cnt = i_latency_limit;
                    st_nxt.state = tlw_pkg::ST_LATENCY;
                end
            end
            tlw_pkg::ST_LATENCY: begin
                // Pulse strobes are not looked at here at all.
                if (st_r.latency_cnt == 8'h00) begin
                    if (i_double_tap_enable && st_r.window_count_field != 8'h00) begin
                        st_nxt.window_cnt = st_r.window_count_field;
                        st_nxt.state = tlw_pkg::ST_WINDOW;
                    end else begin
                        st_nxt.state = tlw_pkg::ST_IDLE;
                    end
                end else if (step_tick) begin
                    st_nxt.latency_cnt = st_r.latency_cnt - 8'h01;
                end
            end
            tlw_pkg::ST_WINDOW: begin
                if (i_pulse_start) begin
                    st_nxt.width_cnt = i_tap_time_limit;
                    st_nxt.state = tlw_pkg::ST_WIDTH;
                end else if (st_r.window_cnt == 8'h00) begin
                    st_nxt.state = tlw_pkg::ST_IDLE;
                end else if (step_tick) begin
                    st_nxt.window_cnt = st_r.window_cnt - 8'h01;
                end
            end
            tlw_pkg::ST_WIDTH: begin
                // The window no longer matters once the start was seen.
                if (i_pulse_end && st_r.width_cnt != 8'h00) begin
                    st_nxt.detected = 1'b1;
                    st_nxt.state = tlw_pkg::ST_IDLE;
                end else if (st_r.width_cnt == 8'h00) begin
                    st_nxt.rejected = 1'b1;
                    st_nxt.state = tlw_pkg::ST_IDLE;
                end else if (half_tick) begin
                    st_nxt.width_cnt = st_r.width_cnt - 8'h01;
                end
            end
        endcase

        st_nxt.latency_active = (st_nxt.state == tlw_pkg::ST_LATENCY);
        st_nxt.window_open = (st_nxt.state == tlw_pkg::ST_WINDOW);

        if (i_reg_wr_en && i_reg_addr == tlw_pkg::SECOND_TAP_WINDOW_ADDR) begin
            st_nxt.window_count_field = i_reg_wdata;
        end
        if (i_reg_rd_en) begin
            st_nxt.rdata = (i_reg_addr == tlw_pkg::SECOND_TAP_WINDOW_ADDR) ? st_r.window_count_field
                                                                           : tlw_pkg::READ_ZERO;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= '0;
            st_r.state <= tlw_pkg::ST_IDLE;
            st_r.window_count_field <= tlw_pkg::SECOND_TAP_WINDOW_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_reg_rdata = st_r.rdata;
    assign o_latency_active = st_r.latency_active;
    assign o_window_open = st_r.window_open;
    assign o_second_tap_detected = st_r.detected;
    assign o_second_tap_rejected = st_r.rejected;

endmodule

`default_nettype wire

// >>> verif/tlw_tap_timer_monitor.sv
/* Port checks for the tap latency and window timer.
   Bound into the timer; one clock, synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module tlw_tap_timer_monitor #(
    parameter int BASE_STEP_CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd_en,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [7:0] i_latency_limit,
    input wire logic i_first_pulse_detected,
    input wire logic i_pulse_start,
    input wire logic i_pulse_end,
    input wire logic o_latency_active,
    input wire logic o_window_open,
    input wire logic o_second_tap_detected,
    input wire logic o_second_tap_rejected
);
    // ====================
    // Checks
    logic [19:0] lat_cnt_r;
    logic [19:0] lat_cnt_nxt;
    default clocking mon_cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    assign lat_cnt_nxt = o_latency_active ? lat_cnt_r + 20'h1 : 20'h0;
    always_ff @(posedge i_clk) begin
        lat_cnt_r <= i_rst ? 20'h0 : lat_cnt_nxt;
    end
    // Two cycles of slack allow for the prescaler realigning on the first pulse.
    lat_len_a: assert property ($fell(o_latency_active)
        |-> 32'(lat_cnt_r) + 2 >= 2 * BASE_STEP_CYCLES * i_latency_limit) else $error("latency too short");
    lat_cause_a: assert property ($rose(o_latency_active) |-> $past(i_first_pulse_detected))
        else $error("latency without first pulse");
    lat_quiet_a: assert property (o_latency_active |-> !o_second_tap_detected && !o_second_tap_rejected)
        else $error("tap result during latency");
    win_follow_a: assert property ($rose(o_window_open) |-> $past(o_latency_active))
        else $error("window not after latency");
    win_excl_a: assert property (!(o_latency_active && o_window_open)) else $error("latency and window both on");
    win_close_a: assert property (o_window_open && i_pulse_start |=> !o_window_open)
        else $error("start did not close window");
    det_end_a: assert property (o_second_tap_detected |-> $past(i_pulse_end))
        else $error("tap without pulse end");
    res_single_a: assert property (o_second_tap_detected || o_second_tap_rejected
        |=> !o_second_tap_detected && !o_second_tap_rejected) else $error("result longer than one cycle");
    rd_other_a: assert property (i_reg_rd_en && i_reg_addr != tlw_pkg::SECOND_TAP_WINDOW_ADDR
        |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    rd_hold_a: assert property (!i_reg_rd_en |=> $stable(o_reg_rdata)) else $error("read data moved");
    cover property (o_second_tap_detected);
    cover property (o_second_tap_rejected);
    cover property ($fell(o_window_open) && !o_second_tap_detected);
endmodule
bind tlw_tap_timer tlw_tap_timer_monitor #(.BASE_STEP_CYCLES(BASE_STEP_CYCLES)) mon_u (.i_clk(i_clk),
    .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_rd_en(i_reg_rd_en), .o_reg_rdata(o_reg_rdata),
    .i_latency_limit(i_latency_limit), .i_first_pulse_detected(i_first_pulse_detected),
    .i_pulse_start(i_pulse_start), .i_pulse_end(i_pulse_end), .o_latency_active(o_latency_active),
    .o_window_open(o_window_open), .o_second_tap_detected(o_second_tap_detected),
    .o_second_tap_rejected(o_second_tap_rejected));
`default_nettype wire

// >>> verif/tlw_host_model.sv
/* Host side of the timer: byte register writes and reads, and the latency and time limits it holds.
   Assumes the caller keeps one access at a time on the shared clock. */
`timescale 1ns/1ns
`default_nettype none
module tlw_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_addr,
    output logic o_wr_en,
    output logic [7:0] o_wdata,
    output logic o_rd_en,
    output logic [7:0] o_latency_limit,
    output logic [7:0] o_time_limit
);
    // ====================
    // Bus tasks
    initial begin
        o_addr = 8'h00;
        o_wr_en = 1'b0;
        o_wdata = 8'h00;
        o_rd_en = 1'b0;
        o_latency_limit = 8'h01;
        o_time_limit = 8'h04;
    end
    // Data is inverted once released so a stale byte cannot pass for a new one.
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr_en <= 1'b1;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        #1 d = i_rdata;
    endtask
    task automatic limits(input logic [7:0] lat, input logic [7:0] tml);
        @(posedge i_clk);
        o_latency_limit <= lat;
        o_time_limit <= tml;
    endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
/* Self-checking bench: sequence lengths per rate, mode and filter, then reset,
   register and second-tap cases. Assumes the host model on the register port. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {logic [2:0] r; logic [1:0] m; logic f; logic [3:0] e;} tlw_row_t;
    // A step of 1.25 ms is 8 cycles with a base step of 4; e is the power of two above it.
    localparam tlw_row_t rows [8] = '{'{3'h0, 2'h0, 1'h0, 4'h0}, '{3'h1, 2'h3, 1'h0, 4'h1},
        '{3'h2, 2'h1, 1'h1, 4'h3}, '{3'h3, 2'h2, 1'h1, 4'h2}, '{3'h4, 2'h0, 1'h1, 4'h5},
        '{3'h5, 2'h1, 1'h0, 4'h5}, '{3'h6, 2'h3, 1'h1, 4'h8}, '{3'h7, 2'h2, 1'h0, 4'h0}};
    logic i_clk = 1'b0, i_rst = 1'b1, fp = 1'b0, ps = 1'b0, pe = 1'b0, dbl = 1'b0, flt = 1'b0;
    logic [2:0] output_sample_rate = 3'h0;
    logic [1:0] mode = 2'h0;
    logic [7:0] addr, wdata, rdata, lat_l, tml;
    logic wr, rd, lat, win, det, rej;
    int error_cnt = 0, n_checks = 0, cyc = 0, n_det = 0, n_rej = 0;
    always #5 i_clk = ~i_clk;
    tlw_host_model host_u (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wr_en(wr), .o_wdata(wdata),
        .o_rd_en(rd), .o_latency_limit(lat_l), .o_time_limit(tml));
    tlw_tap_timer #(.BASE_STEP_CYCLES(4)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr),
        .i_reg_wr_en(wr), .i_reg_wdata(wdata), .i_reg_rd_en(rd), .o_reg_rdata(rdata),
        .i_output_sample_rate(output_sample_rate), .i_power_mode(mode), .i_tap_filter_enable(flt),
        .i_double_tap_enable(dbl), .i_latency_limit(lat_l), .i_tap_time_limit(tml),
        .i_first_pulse_detected(fp), .i_pulse_start(ps), .i_pulse_end(pe), .o_latency_active(lat),
        .o_window_open(win), .o_second_tap_detected(det), .o_second_tap_rejected(rej));
    // ====================
    // Tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        n_det += (det === 1'b1);
        n_rej += (rej === 1'b1);
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        n_checks++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic pulse(input logic [2:0] s);
        @(posedge i_clk);
        {fp, ps, pe} <= s;
        @(posedge i_clk);
        {fp, ps, pe} <= 3'h0;
    endtask
    task automatic wait_win();
        while (win !== 1'b1) begin
            @(posedge i_clk);
            #1;
        end
    endtask
    task automatic run_seq(output int nl, output int nw);
        nl = 0;
        nw = 0;
        pulse(3'h4);
        #1;
        while (lat === 1'b1) begin
            @(posedge i_clk);
            #1 nl++;
        end
        while (win === 1'b1) begin
            @(posedge i_clk);
            #1 nw++;
        end
    endtask
    initial begin
        int nl, nw;
        logic [7:0] d;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        host_u.put(8'h28, 8'h01);
        foreach (rows[k]) begin
            @(posedge i_clk);
            {output_sample_rate, mode, flt, dbl} <= {rows[k].r, rows[k].m, rows[k].f, 1'b1};
            run_seq(nl, nw);
            chk(nl, (8 << rows[k].e) - 1, (8 << rows[k].e) + 3);
            chk(nw, (8 << rows[k].e) - 1, (8 << rows[k].e) + 3);
        end
        $display("test step table done");
        {output_sample_rate, mode, flt} <= 6'h00;
        pulse(3'h4);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1 chk({lat, win, det, rej, rdata}, 0, 0);
        i_rst <= 1'b0;
        host_u.get(8'h28, d);
        chk(d, 0, 0);
        host_u.put(8'h28, 8'hA5);
        host_u.get(8'h28, d);
        chk(d, 'hA5, 'hA5);
        host_u.get(8'h27, d);
        chk(d, 0, 0);
        $display("test reset and registers done");
        host_u.put(8'h28, 8'h00);
        host_u.limits(8'hFF, 8'h04);
        run_seq(nl, nw);
        chk(nl, 2039, 2043);
        chk(nw, 0, 0);
        host_u.put(8'h28, 8'h01);
        host_u.limits(8'h01, 8'h04);
        pulse(3'h4);
        pulse(3'h3);
        wait_win();
        chk(n_det + n_rej, 0, 0);
        pulse(3'h2);
        repeat (8) @(posedge i_clk);
        pulse(3'h1);
        repeat (3) @(posedge i_clk);
        chk(n_det, 1, 1);
        host_u.limits(8'h01, 8'h02);
        pulse(3'h4);
        wait_win();
        pulse(3'h2);
        repeat (20) @(posedge i_clk);
        chk({n_det[3:0], n_rej[3:0]}, 'h11, 'h11);
        run_seq(nl, nw);
        pulse(3'h2);
        pulse(3'h1);
        repeat (20) @(posedge i_clk);
        chk({n_det[3:0], n_rej[3:0]}, 'h11, 'h11);
        dbl <= 1'b0;
        run_seq(nl, nw);
        chk(nl, 7, 11);
        chk(nw, 0, 0);
        $display("test second tap done");
        complete_run();
    end
endmodule
`default_nettype wire
